/* File: include/pcdg_pkg.sv */
// Purpose: Shared constants for the port C / port D general-purpose I/O block
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes: Port C bit 3 does not exist; bits 4 and 5 are input only as port pins and are driven only by USB
package pcdg_pkg;
  localparam logic [7:0] PC_DATA_OFS = 8'h00;
  localparam logic [7:0] PC_LATCH_OFS = 8'h04;
  localparam logic [7:0] PC_DIR_OFS = 8'h08;
  localparam logic [7:0] PD_DATA_OFS = 8'h0C;
  localparam logic [7:0] PD_LATCH_OFS = 8'h10;
  localparam logic [7:0] PD_DIR_OFS = 8'h14;
  // Implemented latch/direction positions 7, 6, 2, 1, 0
  localparam logic [7:0] PC_CTRL_MASK = 8'hC7;
  // Readable pin positions: all but 3
  localparam logic [7:0] PC_PIN_MASK = 8'hF7;
  localparam logic [7:0] PC_DIR_RST = 8'hC7;
  localparam logic [7:0] PC_LATCH_RST = 8'h00;
  localparam logic [7:0] PD_DIR_RST = 8'hFF;
  localparam logic [7:0] PD_LATCH_RST = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* File: include/pcdg_reg_if.sv */
// Purpose: Register write strobes and stored values between bus slave and port logic
// Assumes: Single clock domain
// Notes: Write data is the low byte of the bus word
interface pcdg_reg_if;
  logic [7:0] wdata;
  logic [5:0] wr;
  logic [7:0] pc_lat;
  logic [7:0] pc_dir;
  logic [7:0] pd_lat;
  logic [7:0] pd_dir;
  modport bus (output wdata, output wr, input pc_lat, input pc_dir, input pd_lat, input pd_dir);
  modport regs (input wdata, input wr, output pc_lat, output pc_dir, output pd_lat, output pd_dir);
endinterface

/* File: design/pcdg_regs.sv */
// Purpose: Stored latch and direction registers for ports C and D
// Assumes: Reset already synchronised by the top module
// Notes: wr bit order follows the register offsets divided by four
module pcdg_regs (
  input wire logic clk,
  input wire logic rst_n,
  pcdg_reg_if.regs r
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.pc_lat <= pcdg_pkg::PC_LATCH_RST;
      r.pc_dir <= pcdg_pkg::PC_DIR_RST;
    end else begin
      // Writes to the pin data register also land in the latch
      if (r.wr[0] || r.wr[1]) begin
        r.pc_lat <= r.wdata & pcdg_pkg::PC_CTRL_MASK;
      end
      if (r.wr[2]) begin
        r.pc_dir <= r.wdata & pcdg_pkg::PC_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.pd_lat <= pcdg_pkg::PD_LATCH_RST;
      r.pd_dir <= pcdg_pkg::PD_DIR_RST;
    end else begin
      if (r.wr[3] || r.wr[4]) begin
        r.pd_lat <= r.wdata;
      end
      if (r.wr[5]) begin
        r.pd_dir <= r.wdata;
      end
    end
  end
endmodule

/* File: design/pcdg_top.sv */
// Purpose: Port C (7 pins) and port D (8 pins) general-purpose I/O with peripheral overrides
// Assumes: AHB-Lite slave, peripherals outside supply override controls
// Notes: Pin output enables are active low; pins are three signals each
//
// Implementation choices: the register addresses and the AHB-Lite register port.
module pcdg_top #(
  parameter int PD_PRESENT = 1
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [7:0] PC_IN,
  output logic [7:0] PC_OUT,
  output logic [7:0] PC_OE_N,
  input wire logic [7:0] PD_IN,
  output logic [7:0] PD_OUT,
  output logic [7:0] PD_OE_N,
  input wire logic SEC_OSC_EN,
  input wire logic USB_MODULE_ENABLE,
  input wire logic USB_ONCHIP_XCVR_DIS,
  input wire logic USB_EXT_XCVR,
  input wire logic EXT_XCVR_OUTPUT_ENABLE,
  input wire logic USB_DRIVE,
  input wire logic USB_MINUS_OUT,
  input wire logic USB_PLUS_OUT,
  input wire logic CCP_OUT_EN,
  input wire logic CCP_OUT,
  input wire logic SERIAL_TX_EN,
  input wire logic SERIAL_TX,
  input wire logic SERIAL_DT_OUT_EN,
  input wire logic SERIAL_DT_OUT,
  output logic USB_MINUS_IN,
  output logic USB_PLUS_IN,
  output logic EXT_XCVR_MINUS_IN,
  output logic EXT_XCVR_PLUS_IN,
  output logic CAPTURE_IN,
  output logic SEC_COUNTER_CLOCK_IN,
  output logic SERIAL_CLOCK_IN,
  output logic SERIAL_RX_IN
);
  logic rst_meta_r;
  logic rst_n_r;
  logic [7:0] pc_meta_r;
  logic [7:0] pc_sync_r;
  logic [7:0] pd_meta_r;
  logic [7:0] pd_sync_r;
  logic dph_valid_r;
  logic dph_write_r;
  logic [7:0] dph_addr_r;
  logic [7:0] rd_nxt;
  logic [7:0] pc_out_nxt;
  logic [7:0] pc_oe_n_nxt;
  logic [7:0] pc_read;
  logic pins45_gpio;
  logic [7:0] pc_lat_fwd;
  logic [7:0] pc_dir_fwd;
  logic [7:0] pd_lat_fwd;
  logic [7:0] pd_dir_fwd;

  pcdg_reg_if rif ();

  pcdg_regs u_regs (
    .clk(MCLK),
    .rst_n(rst_n_r),
    .r(rif)
  );

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pins are asynchronous; two stages before any reader
  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pc_meta_r <= 8'h00;
      pc_sync_r <= 8'h00;
      pd_meta_r <= 8'h00;
      pd_sync_r <= 8'h00;
    end else begin
      pc_meta_r <= PC_IN;
      pc_sync_r <= pc_meta_r;
      pd_meta_r <= PD_IN;
      pd_sync_r <= pd_meta_r;
    end
  end

  // Address phase capture; every transfer completes with no wait state
  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else if (HREADY) begin
      dph_valid_r <= HSEL && (HTRANS == pcdg_pkg::HTRANS_NONSEQ || HTRANS == 2'h3);
      dph_write_r <= HWRITE;
      dph_addr_r <= HADDR[7:0];
    end
  end

  always_comb begin
    rif.wdata = HWDATA[7:0];
    rif.wr = 6'h00;
    if (dph_valid_r && dph_write_r) begin
      unique case (dph_addr_r)
        pcdg_pkg::PC_DATA_OFS: rif.wr[0] = 1'b1;
        pcdg_pkg::PC_LATCH_OFS: rif.wr[1] = 1'b1;
        pcdg_pkg::PC_DIR_OFS: rif.wr[2] = 1'b1;
        pcdg_pkg::PD_DATA_OFS: rif.wr[3] = (PD_PRESENT != 0);
        pcdg_pkg::PD_LATCH_OFS: rif.wr[4] = (PD_PRESENT != 0);
        pcdg_pkg::PD_DIR_OFS: rif.wr[5] = (PD_PRESENT != 0);
        default: rif.wr = 6'h00;
      endcase
    end
  end

  // Back-to-back transfers: the read's address phase meets the write's data phase,
  // so the stored value is not yet updated; forward the word being written
  always_comb begin
    pc_lat_fwd = rif.pc_lat;
    pc_dir_fwd = rif.pc_dir;
    pd_lat_fwd = rif.pd_lat;
    pd_dir_fwd = rif.pd_dir;
    if (rif.wr[0] || rif.wr[1]) begin
      pc_lat_fwd = rif.wdata & pcdg_pkg::PC_CTRL_MASK;
    end
    if (rif.wr[2]) begin
      pc_dir_fwd = rif.wdata & pcdg_pkg::PC_CTRL_MASK;
    end
    if (rif.wr[3] || rif.wr[4]) begin
      pd_lat_fwd = rif.wdata;
    end
    if (rif.wr[5]) begin
      pd_dir_fwd = rif.wdata;
    end
  end

  // Pins four and five read as port data only with USB fully off
  assign pins45_gpio = !USB_MODULE_ENABLE && USB_ONCHIP_XCVR_DIS;

  always_comb begin
    pc_read = pc_sync_r & pcdg_pkg::PC_PIN_MASK;
    if (!pins45_gpio) begin
      pc_read[5:4] = 2'b00;
    end
    // Oscillator pins read as zero in the port data register; pin 0 still feeds SEC_COUNTER_CLOCK_IN
    if (SEC_OSC_EN) begin
      pc_read[1:0] = 2'b00;
    end
  end

  // Read data is prepared in the address phase and registered
  always_comb begin
    rd_nxt = 8'h00;
    if (HSEL && HTRANS[1] && !HWRITE) begin
      unique case (HADDR[7:0])
        pcdg_pkg::PC_DATA_OFS: rd_nxt = pc_read;
        pcdg_pkg::PC_LATCH_OFS: rd_nxt = pc_lat_fwd;
        pcdg_pkg::PC_DIR_OFS: rd_nxt = pc_dir_fwd;
        pcdg_pkg::PD_DATA_OFS: rd_nxt = (PD_PRESENT != 0) ? pd_sync_r : 8'h00;
        pcdg_pkg::PD_LATCH_OFS: rd_nxt = (PD_PRESENT != 0) ? pd_lat_fwd : 8'h00;
        pcdg_pkg::PD_DIR_OFS: rd_nxt = (PD_PRESENT != 0) ? pd_dir_fwd : 8'h00;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      if (HREADY) begin
        HRDATA <= {24'h00_0000, rd_nxt};
      end
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Pin drive: peripheral overrides replace latch and direction, except CCP and TX, which replace only the latch value on output pins; registers untouched
  always_comb begin
    pc_out_nxt = rif.pc_lat;
    pc_oe_n_nxt = rif.pc_dir | ~pcdg_pkg::PC_CTRL_MASK;
    if (SEC_OSC_EN) begin
      pc_oe_n_nxt[1:0] = 2'b11;
      pc_out_nxt[1:0] = 2'b00;
    end else if (USB_MODULE_ENABLE && USB_EXT_XCVR) begin
      // Output enable placed on pin one, as the pin-function table shows
      pc_oe_n_nxt[1] = 1'b0;
      pc_out_nxt[1] = EXT_XCVR_OUTPUT_ENABLE;
    end
    if (CCP_OUT_EN && !rif.pc_dir[2]) begin
      pc_out_nxt[2] = CCP_OUT;
    end
    if (SERIAL_TX_EN && !rif.pc_dir[6]) begin
      pc_out_nxt[6] = SERIAL_TX;
    end
    if (SERIAL_DT_OUT_EN) begin
      pc_oe_n_nxt[7] = 1'b0;
      pc_out_nxt[7] = SERIAL_DT_OUT;
    end
    if (USB_MODULE_ENABLE && !USB_EXT_XCVR && USB_DRIVE) begin
      pc_oe_n_nxt[5:4] = 2'b00;
      pc_out_nxt[5:4] = {USB_PLUS_OUT, USB_MINUS_OUT};
    end else begin
      pc_oe_n_nxt[5:4] = 2'b11;
      pc_out_nxt[5:4] = 2'b00;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PC_OUT <= 8'h00;
      PC_OE_N <= 8'hFF;
      PD_OUT <= 8'h00;
      PD_OE_N <= 8'hFF;
    end else begin
      PC_OUT <= pc_out_nxt;
      PC_OE_N <= pc_oe_n_nxt;
      PD_OUT <= rif.pd_lat;
      PD_OE_N <= (PD_PRESENT != 0) ? rif.pd_dir : 8'hFF;
    end
  end

  // Peripheral input paths from synchronised pins
  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      USB_MINUS_IN <= 1'b0;
      USB_PLUS_IN <= 1'b0;
      EXT_XCVR_MINUS_IN <= 1'b0;
      EXT_XCVR_PLUS_IN <= 1'b0;
      CAPTURE_IN <= 1'b0;
      SEC_COUNTER_CLOCK_IN <= 1'b0;
      SERIAL_CLOCK_IN <= 1'b0;
      SERIAL_RX_IN <= 1'b0;
    end else begin
      USB_MINUS_IN <= pc_sync_r[4];
      USB_PLUS_IN <= pc_sync_r[5];
      EXT_XCVR_MINUS_IN <= USB_EXT_XCVR & pc_sync_r[4];
      EXT_XCVR_PLUS_IN <= USB_EXT_XCVR & pc_sync_r[5];
      CAPTURE_IN <= rif.pc_dir[2] & pc_sync_r[2];
      SEC_COUNTER_CLOCK_IN <= pc_sync_r[0];
      SERIAL_CLOCK_IN <= rif.pc_dir[6] & pc_sync_r[6];
      SERIAL_RX_IN <= pc_sync_r[7];
    end
  end
endmodule

/* File: bench/pcdg_top_asserts.sv */
// Purpose: Port-level checks of pcdg_top
// Assumes: Overrides reach the pins one edge later
// Notes: Checks other than pin three and read data high bits wait for the reset synchroniser to drain
module pcdg_top_asserts (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic [31:0] HRDATA,
  input wire logic [7:0] PC_IN,
  input wire logic [7:0] PC_OUT,
  input wire logic [7:0] PC_OE_N,
  input wire logic SEC_OSC_EN,
  input wire logic USB_MODULE_ENABLE,
  input wire logic USB_ONCHIP_XCVR_DIS,
  input wire logic USB_EXT_XCVR,
  input wire logic EXT_XCVR_OUTPUT_ENABLE,
  input wire logic USB_DRIVE,
  input wire logic USB_MINUS_OUT,
  input wire logic USB_PLUS_OUT,
  input wire logic CCP_OUT_EN,
  input wire logic CCP_OUT,
  input wire logic SERIAL_TX_EN,
  input wire logic SERIAL_TX,
  input wire logic SERIAL_RX_IN
);
  logic [2:0] up_r;
  logic ok;
  logic ux;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // Internal reset outlives the pin by two edges
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  assign ok = (up_r == 3'h7);
  assign ux = USB_MODULE_ENABLE && USB_EXT_XCVR;
  AST_PIN3_ABSENT: assert property (PC_OE_N[3] && !PC_OUT[3])
    else $error("pin three driven");
  AST_PINS45_GP: assert property (ok && $past(!USB_MODULE_ENABLE) |-> PC_OE_N[5:4] == 2'h3)
    else $error("pins four five driven in port mode");
  AST_PINS45_EXT: assert property (ok && $past(ux) |-> PC_OE_N[5:4] == 2'h3)
    else $error("pins four five driven with external transceiver");
  AST_PINS45_USB: assert property (ok && $past(USB_MODULE_ENABLE && !USB_EXT_XCVR &&
    !USB_ONCHIP_XCVR_DIS && USB_DRIVE) |-> PC_OE_N[5:4] == 2'h0 &&
    PC_OUT[5:4] == {$past(USB_PLUS_OUT), $past(USB_MINUS_OUT)})
    else $error("pins four five not following transceiver");
  AST_XCVR_OE_PIN1: assert property (ok && $past(ux && !SEC_OSC_EN) |->
    !PC_OE_N[1] && PC_OUT[1] == $past(EXT_XCVR_OUTPUT_ENABLE))
    else $error("transceiver enable missing on pin one");
  AST_OSC_PINS: assert property (ok && $past(SEC_OSC_EN && !ux) |-> PC_OE_N[1:0] == 2'h3)
    else $error("oscillator pins driven");
  AST_CCP_PIN2: assert property (ok && $past(CCP_OUT_EN) && !PC_OE_N[2] |->
    PC_OUT[2] == $past(CCP_OUT))
    else $error("compare output lost on pin two");
  AST_TX_PIN6: assert property (ok && $past(SERIAL_TX_EN) && !PC_OE_N[6] |->
    PC_OUT[6] == $past(SERIAL_TX))
    else $error("transmit lost on pin six");
  AST_RX_PIN7: assert property (ok |-> SERIAL_RX_IN == $past(PC_IN[7], 3))
    else $error("receive input wrong");
  AST_RDATA_HIGH: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule
bind pcdg_top pcdg_top_asserts i_pcdg_top_asserts (.*);

/* File: bench/pcdg_pins_model.sv */
// Purpose: Outside world on the port C and D pads
// Assumes: No pull resistors on the pads
// Notes: Bench changes the outside levels often, so a stale value is not mistaken
module pcdg_pins_model (
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe_n,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe_n,
  input wire logic [7:0] ext_c,
  input wire logic [7:0] ext_d,
  output logic [7:0] pc_in,
  output logic [7:0] pd_in
);
  assign pc_in = (pc_oe_n & ext_c) | (~pc_oe_n & pc_out);
  assign pd_in = (pd_oe_n & ext_d) | (~pd_oe_n & pd_out);
endmodule

/* File: bench/test_port_c_d_gpio.sv */
// Purpose: Self-checking bench of pcdg_top
// Assumes: Zero-wait AHB-Lite slave, three-edge pin sampling
// Notes: Random register values from a fixed seed
module test_port_c_d_gpio;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK, ARST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, r0, r1, r2, r3;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [7:0] PC_IN, PC_OUT, PC_OE_N, PD_IN, PD_OUT, PD_OE_N, ext_c, ext_d, e;
  logic SEC_OSC_EN, USB_MODULE_ENABLE, USB_ONCHIP_XCVR_DIS, USB_EXT_XCVR, EXT_XCVR_OUTPUT_ENABLE;
  logic USB_DRIVE, USB_MINUS_OUT, USB_PLUS_OUT, CCP_OUT_EN, CCP_OUT, SERIAL_TX_EN, SERIAL_TX;
  logic SERIAL_DT_OUT_EN, SERIAL_DT_OUT, USB_MINUS_IN, USB_PLUS_IN, EXT_XCVR_MINUS_IN;
  logic EXT_XCVR_PLUS_IN, CAPTURE_IN, SEC_COUNTER_CLOCK_IN, SERIAL_CLOCK_IN, SERIAL_RX_IN;
  int seed = 29;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  assign HREADY = HREADYOUT;
  pcdg_top i_pcdg_top (.*);
  pcdg_pins_model i_pcdg_pins_model (.pc_out(PC_OUT), .pc_oe_n(PC_OE_N), .pd_out(PD_OUT),
    .pd_oe_n(PD_OE_N), .ext_c(ext_c), .ext_d(ext_d), .pc_in(PC_IN), .pd_in(PD_IN));
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= pcdg_pkg::HTRANS_NONSEQ;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wd;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, exp);
  endtask
  // Overrides packed low bit first: osc, usb on, xcvr off, ext, oe, drive, -, +, ccp, tx, dt
  task automatic set_ov(input logic [13:0] v);
    {SERIAL_DT_OUT, SERIAL_DT_OUT_EN, SERIAL_TX, SERIAL_TX_EN, CCP_OUT, CCP_OUT_EN, USB_PLUS_OUT,
      USB_MINUS_OUT, USB_DRIVE, EXT_XCVR_OUTPUT_ENABLE, USB_EXT_XCVR, USB_ONCHIP_XCVR_DIS,
      USB_MODULE_ENABLE, SEC_OSC_EN} <= v;
  endtask
  function automatic logic [31:0] pin_exp(input logic [7:0] lat, input logic [7:0] dir,
    input logic [7:0] ex, input logic [7:0] msk);
    pin_exp = {24'h0, ((~dir & lat) | (dir & ex)) & msk};
  endfunction
  initial begin
    ARST_N = 1'b0;
    {HSEL, HWRITE, HADDR, HWDATA, HTRANS, ext_c, ext_d} = '0;
    HSIZE = pcdg_pkg::HSIZE_WORD;
    set_ov(14'h0004);
    repeat (8) @(posedge MCLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    chk("pc_oe_n", {24'h0, PC_OE_N}, 32'hFF);
    chk("pd_oe_n", {24'h0, PD_OE_N}, 32'hFF);
    rd_chk(pcdg_pkg::PC_DIR_OFS, {24'h0, pcdg_pkg::PC_CTRL_MASK});
    rd_chk(pcdg_pkg::PD_DIR_OFS, 32'hFF);
    rd_chk(pcdg_pkg::PC_LATCH_OFS, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      r0 = $random(seed);
      r1 = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : $random(seed);
      r2 = $random(seed);
      r3 = r1 ^ $random(seed);
      e = $random(seed);
      ext_c <= e;
      ext_d <= ~e;
      bus(1'b1, pcdg_pkg::PC_LATCH_OFS, r0);
      bus(1'b1, pcdg_pkg::PC_DIR_OFS, r1);
      bus(1'b1, pcdg_pkg::PD_LATCH_OFS, r2);
      bus(1'b1, pcdg_pkg::PD_DIR_OFS, r3);
      repeat (5) @(posedge MCLK);
      chk("pc_oe_n", {24'h0, PC_OE_N}, {24'h0, r1[7:0] | 8'h38});
      chk("pd_oe_n", {24'h0, PD_OE_N}, {24'h0, r3[7:0]});
      rd_chk(pcdg_pkg::PC_LATCH_OFS, r0 & 32'hC7);
      rd_chk(pcdg_pkg::PC_DIR_OFS, r1 & 32'hC7);
      rd_chk(pcdg_pkg::PD_LATCH_OFS, r2 & 32'hFF);
      rd_chk(pcdg_pkg::PD_DIR_OFS, r3 & 32'hFF);
      rd_chk(pcdg_pkg::PC_DATA_OFS, pin_exp(r0[7:0], r1[7:0] & 8'hC7 | 8'h38, e, 8'hF7));
      rd_chk(pcdg_pkg::PD_DATA_OFS, pin_exp(r2[7:0], r3[7:0], ~e, 8'hFF));
    end
    bus(1'b1, pcdg_pkg::PC_DATA_OFS, 32'h5A);
    rd_chk(pcdg_pkg::PC_LATCH_OFS, 32'h42);
    bus(1'b1, pcdg_pkg::PD_DATA_OFS, 32'hA5);
    rd_chk(pcdg_pkg::PD_LATCH_OFS, 32'hA5);
    $display("test registers done");
    bus(1'b1, pcdg_pkg::PC_LATCH_OFS, 32'h0);
    bus(1'b1, pcdg_pkg::PC_DIR_OFS, 32'h81);
    repeat (300) begin
      @(posedge MCLK);
      set_ov(14'($random(seed)));
      ext_c <= $random(seed);
    end
    set_ov(14'h0503);
    ext_c <= 8'hFF;
    repeat (5) @(posedge MCLK);
    rd_chk(pcdg_pkg::PC_DIR_OFS, 32'h81);
    rd_chk(pcdg_pkg::PC_DATA_OFS, 32'h80);
    set_ov(14'h0000);
    repeat (5) @(posedge MCLK);
    rd_chk(pcdg_pkg::PC_DATA_OFS, 32'h81);
    set_ov(14'h0004);
    repeat (5) @(posedge MCLK);
    rd_chk(pcdg_pkg::PC_DATA_OFS, 32'hB1);
    chk("usb_minus_in", {31'h0, USB_MINUS_IN}, 32'h1);
    chk("usb_plus_in", {31'h0, USB_PLUS_IN}, 32'h1);
    chk("sec_clk_in", {31'h0, SEC_COUNTER_CLOCK_IN}, 32'h1);
    chk("serial_rx_in", {31'h0, SERIAL_RX_IN}, 32'h1);
    chk("serial_clk_in", {31'h0, SERIAL_CLOCK_IN}, 32'h0);
    chk("capture_in", {31'h0, CAPTURE_IN}, 32'h0);
    chk("ext_minus_in", {31'h0, EXT_XCVR_MINUS_IN}, 32'h0);
    chk("hresp", {31'h0, HRESP}, 32'h0);
    bus(1'b1, pcdg_pkg::PC_DIR_OFS, 32'hC5);
    set_ov(14'h001A);
    repeat (5) @(posedge MCLK);
    chk("capture_in", {31'h0, CAPTURE_IN}, 32'h1);
    chk("serial_clk_in", {31'h0, SERIAL_CLOCK_IN}, 32'h1);
    chk("ext_minus_in", {31'h0, EXT_XCVR_MINUS_IN}, 32'h1);
    chk("ext_plus_in", {31'h0, EXT_XCVR_PLUS_IN}, 32'h1);
    chk("pin1_oe_n", {31'h0, PC_OE_N[1]}, 32'h0);
    chk("pin1_out", {31'h0, PC_OUT[1]}, 32'h1);
    chk("pins45_oe_n", {30'h0, PC_OE_N[5:4]}, 32'h3);
    set_ov(14'h0004);
    bus(1'b1, pcdg_pkg::PC_DIR_OFS, 32'h81);
    bus(1'b1, 8'h18, 32'hFF);
    rd_chk(8'h18, 32'h0);
    rd_chk(pcdg_pkg::PC_DIR_OFS, 32'h81);
    $display("test overrides done");
    give_verdict();
  end
endmodule
